// [mac_link_statistics_and_routing_config.sv]
// Link statistics counters and messaging configuration bank with host command port
`timescale 1ns/10ps
module mac_link_statistics_and_routing_config
	import stats_routing_pkg::*;
#(
	parameter int POLL_PERIOD_CYCLES = POLL_CYCLES
)(
	input  wire logic            clk_sys,
	input  wire logic            reset_n,
	input  wire logic            clk_en,
	input  wire host_cmd_type    host_cmd,
	output host_rsp_type         host_rsp,
	input  wire mac_event_type   mac_event,
	input  wire rssi_sample_type rssi_sample,
	input  wire hop_timeout_type hop_timeout,
	input  wire logic [5:0]      network_hop_count,
	input  wire logic            broadcast_received,
	input  wire logic            poll_request_from_end,
	output logic                 repeat_broadcast,
	output logic                 route_enable,
	output logic                 hold_p2mp_unicast,
	output logic                 release_p2mp_unicast,
	output logic                 poll_send,
	output logic [5:0]           broadcast_hop_effective
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == COUNT_MAX) ? v : 16'(v + 16'h0001);
	endfunction

	function automatic logic [15:0] wrap_inc(input logic [15:0] v);
		wrap_inc = 16'(v + 16'h0001);
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] counts [NUM_COUNTERS];
	logic [7:0]  last_signal_strength;
	logic [15:0] unicast_hop_timeout;
	logic [15:0] broadcast_hop_timeout;
	logic [2:0]  messaging_options;
	logic [5:0]  broadcast_hop_limit;
	logic [31:0] poll_timer;

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	wire         do_write   = host_cmd.valid & host_cmd.write;
	wire         sel_count  = host_cmd.sel < 4'(NUM_COUNTERS);
	wire         sel_opts   = host_cmd.sel == SEL_OPTIONS;
	wire         sel_hops   = host_cmd.sel == SEL_HOP_LIMIT;
	wire [2:0]   opts_value = host_cmd.wdata[2:0];

	// Options outside 0..6 or with coordinator and poller both set are refused
	wire opts_bad = (host_cmd.wdata > 16'(OPTIONS_MAX))
		| (opts_value[OPT_COORD] & opts_value[OPT_POLL]);
	wire hops_bad = host_cmd.wdata > 16'(HOP_MAX);

	wire wr_opts_ok = do_write & sel_opts & ~opts_bad;
	wire wr_hops_ok = do_write & sel_hops & ~hops_bad;

	// Read-only, unmapped or out-of-range writes answer with an error
	wire write_err = do_write & ~sel_count
		& ~(sel_opts & ~opts_bad) & ~(sel_hops & ~hops_bad);
	wire read_err  = host_cmd.valid & ~host_cmd.write & (host_cmd.sel > SEL_HOP_LIMIT);

	logic [15:0] read_mux;
	always_comb begin
		read_mux = 16'h0000;
		case (host_cmd.sel)
			SEL_SIGNAL:    read_mux = {8'h00, last_signal_strength};
			SEL_UNI_TMO:   read_mux = unicast_hop_timeout;
			SEL_BC_TMO:    read_mux = broadcast_hop_timeout;
			SEL_OPTIONS:   read_mux = {13'h0, messaging_options};
			SEL_HOP_LIMIT: read_mux = {10'h0, broadcast_hop_limit};
			default: begin
				if (sel_count) begin
					read_mux = counts[host_cmd.sel[2:0]];
				end
			end
		endcase
	end

	// ----------------------------------------
	// Statistics counters
	// ----------------------------------------
	// A host load wins over an event in the same cycle, so the written value sticks
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_COUNTERS; i++) begin
				counts[i] <= COUNT_RESET;
			end
		end else if (clk_en) begin
			for (int i = 0; i < NUM_COUNTERS; i++) begin
				if (do_write && host_cmd.sel == 4'(i)) begin
					counts[i] <= host_cmd.wdata;
				end else if (mac_event[i]) begin
					if (i == 0) begin
						counts[i] <= wrap_inc(counts[i]);
					end else begin
						counts[i] <= sat_inc(counts[i]);
					end
				end
			end
		end
	end

	// ----------------------------------------
	// Signal strength and hop timeouts
	// ----------------------------------------
	// The MAC hands over only the final hop's measurement; no path averaging
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			last_signal_strength <= SIGNAL_RESET;
		end else if (clk_en && rssi_sample.valid) begin
			last_signal_strength <= rssi_sample.magnitude;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			unicast_hop_timeout   <= UNI_TMO_RESET;
			broadcast_hop_timeout <= BC_TMO_RESET;
		end else if (clk_en && hop_timeout.update) begin
			unicast_hop_timeout   <= hop_timeout.unicast_ms;
			broadcast_hop_timeout <= hop_timeout.broadcast_ms;
		end
	end

	// ----------------------------------------
	// Messaging configuration
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			messaging_options   <= OPTIONS_RESET;
			broadcast_hop_limit <= HOP_LIMIT_RESET;
		end else if (clk_en) begin
			if (wr_opts_ok) begin
				messaging_options <= opts_value;
			end
			if (wr_hops_ok) begin
				broadcast_hop_limit <= host_cmd.wdata[5:0];
			end
		end
	end

	// ----------------------------------------
	// Host answer
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			host_rsp <= '0;
		end else if (clk_en) begin
			host_rsp.valid <= host_cmd.valid;
			host_rsp.error <= write_err | read_err;
			host_rsp.rdata <= (host_cmd.valid & ~host_cmd.write) ? read_mux : 16'h0000;
		end
	end

	// ----------------------------------------
	// Routing and indirect messaging
	// ----------------------------------------
	assign route_enable         = ~messaging_options[OPT_NOROUTE];
	assign repeat_broadcast     = broadcast_received & route_enable;
	assign hold_p2mp_unicast    = messaging_options[OPT_COORD];
	assign release_p2mp_unicast = hold_p2mp_unicast & poll_request_from_end;

	// Zero asks for the widest radius, which is then bounded by the network hop count.
	// The hop count itself only caps this value; it never stops a route.
	wire [5:0] nh_clamped = (network_hop_count > HOP_MAX) ? HOP_MAX : network_hop_count;
	wire       use_nh     = (broadcast_hop_limit == 6'h00) | (broadcast_hop_limit > nh_clamped);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			broadcast_hop_effective <= HOP_LIMIT_RESET;
		end else if (clk_en) begin
			broadcast_hop_effective <= use_nh ? nh_clamped : broadcast_hop_limit;
		end
	end

	// ----------------------------------------
	// Poll timer
	// ----------------------------------------
	// Timer restarts whenever polling is off, so the first poll comes one period after enable
	wire poll_on   = messaging_options[OPT_POLL];
	wire poll_done = poll_timer >= 32'(POLL_PERIOD_CYCLES - 1);
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			poll_timer <= 32'h00000000;
			poll_send  <= 1'b0;
		end else if (clk_en) begin
			poll_send <= poll_on & poll_done;
			if (!poll_on || poll_done) begin
				poll_timer <= 32'h00000000;
			end else begin
				poll_timer <= 32'(poll_timer + 32'h00000001);
			end
		end
	end

endmodule

// [stats_routing_pkg.sv]
// Constants and carrier types for the link statistics and routing configuration bank
package stats_routing_pkg;

	// ----------------------------------------
	// Register selectors
	// ----------------------------------------
	localparam logic [3:0] SEL_TX_BYTE    = 4'h0;
	localparam logic [3:0] SEL_RX_ERROR   = 4'h1;
	localparam logic [3:0] SEL_GOOD_FRAME = 4'h2;
	localparam logic [3:0] SEL_ACK_TMO    = 4'h3;
	localparam logic [3:0] SEL_RETRY_EXH  = 4'h4;
	localparam logic [3:0] SEL_ACKED_UNI  = 4'h5;
	localparam logic [3:0] SEL_SIGNAL     = 4'h6;
	localparam logic [3:0] SEL_UNI_TMO    = 4'h7;
	localparam logic [3:0] SEL_BC_TMO     = 4'h8;
	localparam logic [3:0] SEL_OPTIONS    = 4'h9;
	localparam logic [3:0] SEL_HOP_LIMIT  = 4'hA;

	// ----------------------------------------
	// Widths, limits and reset values
	// ----------------------------------------
	localparam int          NUM_COUNTERS    = 6;
	localparam logic [15:0] COUNT_MAX       = 16'hFFFF;
	localparam logic [15:0] COUNT_RESET     = 16'h0000;
	localparam logic [7:0]  SIGNAL_RESET    = 8'h00;
	localparam logic [15:0] UNI_TMO_RESET   = 16'h00CF;
	localparam logic [15:0] BC_TMO_RESET    = 16'h01BE;
	localparam logic [2:0]  OPTIONS_RESET   = 3'h0;
	localparam logic [2:0]  OPTIONS_MAX     = 3'h6;
	localparam logic [5:0]  HOP_LIMIT_RESET = 6'h00;
	localparam logic [5:0]  HOP_MAX         = 6'h20;

	// ----------------------------------------
	// Messaging option bit positions
	// ----------------------------------------
	localparam int OPT_COORD   = 0;
	localparam int OPT_NOROUTE = 1;
	localparam int OPT_POLL    = 2;

	// ----------------------------------------
	// Poll timing
	// ----------------------------------------
	localparam int CLK_HZ       = 40_000_000;
	localparam int POLL_MS      = 100;
	localparam int POLL_CYCLES  = (CLK_HZ / 1000) * POLL_MS;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [3:0]  sel;
		logic [15:0] wdata;
	} host_cmd_type;

	typedef struct packed {
		logic        valid;
		logic        error;
		logic [15:0] rdata;
	} host_rsp_type;

	// Bit order matches counter index order of the selectors
	typedef struct packed {
		logic acked_unicast;
		logic retry_exhausted;
		logic ack_timeout;
		logic good_frame;
		logic rx_error;
		logic tx_byte;
	} mac_event_type;

	typedef struct packed {
		logic        valid;
		logic [7:0]  magnitude;
	} rssi_sample_type;

	typedef struct packed {
		logic        update;
		logic [15:0] unicast_ms;
		logic [15:0] broadcast_ms;
	} hop_timeout_type;

endpackage

// [link_stats_assertions.sv]
// Port checker for the link statistics and routing bank
`timescale 1ns/10ps
module link_stats_checker
	import stats_routing_pkg::*;
#(
	parameter int POLL_PERIOD_CYCLES = 8
)(
	input wire logic         clk_sys,
	input wire logic         reset_n,
	input wire logic         clk_en,
	input wire host_cmd_type host_cmd,
	input wire host_rsp_type host_rsp,
	input wire logic         broadcast_received,
	input wire logic         poll_request_from_end,
	input wire logic [5:0]   network_hop_count,
	input wire logic         repeat_broadcast,
	input wire logic         route_enable,
	input wire logic         hold_p2mp_unicast,
	input wire logic         release_p2mp_unicast,
	input wire logic         poll_send,
	input wire logic [5:0]   broadcast_hop_effective
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire acc = clk_en && host_cmd.valid;
	wire opt_w = acc && host_cmd.write && host_cmd.sel == SEL_OPTIONS;
	wire opt_ok = host_cmd.wdata <= 16'h0006 && !(host_cmd.wdata[0] && host_cmd.wdata[2]);
	wire ro_w = acc && host_cmd.write && host_cmd.sel inside {SEL_SIGNAL, SEL_UNI_TMO, SEL_BC_TMO};
	property p_rsp; acc |=> host_rsp.valid; endproperty
	a_rsp: assert property (p_rsp) else $error("no answer to command");
	property p_ro; ro_w |=> host_rsp.error; endproperty
	a_ro: assert property (p_ro) else $error("read-only write accepted");
	property p_optbad; opt_w && !opt_ok |=> host_rsp.valid && host_rsp.error; endproperty
	a_optbad: assert property (p_optbad) else $error("bad options accepted");
	property p_route;
		opt_w && opt_ok |=> route_enable == !$past(host_cmd.wdata[1]) && hold_p2mp_unicast == $past(host_cmd.wdata[0]);
	endproperty
	a_route: assert property (p_route) else $error("options not applied");
	property p_rep; repeat_broadcast == (broadcast_received && route_enable); endproperty
	a_rep: assert property (p_rep) else $error("broadcast repeat wrong");
	property p_rel; release_p2mp_unicast == (hold_p2mp_unicast && poll_request_from_end); endproperty
	a_rel: assert property (p_rel) else $error("held unicast release wrong");
	property p_hop;
		clk_en |=> broadcast_hop_effective <= (($past(network_hop_count) > HOP_MAX) ? HOP_MAX : $past(network_hop_count));
	endproperty
	a_hop: assert property (p_hop) else $error("hop limit above hop count");
	property p_poll; poll_send |=> !poll_send [*7]; endproperty
	a_poll: assert property (p_poll) else $error("polls too close");
	c_poll: cover property (poll_send);
	c_rep: cover property (repeat_broadcast);
	c_rel: cover property (release_p2mp_unicast);
endmodule
bind mac_link_statistics_and_routing_config link_stats_checker #(.POLL_PERIOD_CYCLES(POLL_PERIOD_CYCLES)) u_chk (
	.clk_sys, .reset_n, .clk_en, .host_cmd, .host_rsp, .broadcast_received, .poll_request_from_end,
	.network_hop_count, .repeat_broadcast, .route_enable, .hold_p2mp_unicast, .release_p2mp_unicast,
	.poll_send, .broadcast_hop_effective
);

// [mac_link_model.sv]
// Behavioural MAC and radio side feeding events, signal samples and timeouts
`timescale 1ns/10ps
module mac_link_model
	import stats_routing_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	input  wire logic [5:0] fire,
	input  wire logic       rssi_go,
	input  wire logic       tmo_go,
	output mac_event_type   mac_event,
	output rssi_sample_type rssi_sample,
	output hop_timeout_type hop_timeout
);
	// Data is inverted outside its strobe so a stale value is never mistaken for a sample
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mac_event <= '0;
			rssi_sample <= '0;
			hop_timeout <= '0;
		end else begin
			mac_event <= fire;
			rssi_sample <= '{rssi_go, rssi_go ? 8'h60 : 8'h9F};
			hop_timeout <= '{tmo_go, tmo_go ? 16'h0123 : 16'hFEDC, tmo_go ? 16'h0456 : 16'hFBA9};
		end
	end
endmodule

// [tb.sv]
// Self-checking bench for the link statistics and routing bank
`timescale 1ns/10ps
module tb
	import stats_routing_pkg::*;
;
	logic            clk_sys = 1'h0;
	logic            reset_n = 1'h0;
	logic            rssi_go = 1'h0;
	logic            tmo_go = 1'h0;
	logic            clk_en = 1'h1;
	logic [5:0]      fire = '0;
	logic [5:0]      nh = 6'h10;
	logic [5:0]      cyc = '0;
	logic [2:0]      last;
	host_cmd_type    host_cmd = '0;
	host_rsp_type    host_rsp;
	mac_event_type   mac_event;
	rssi_sample_type rssi_sample;
	hop_timeout_type hop_timeout;
	logic            rep, route, hold, rel, poll;
	logic [5:0]      hop;
	int              bad_count = 0, checked = 0, n, cnt;
	initial forever #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) #1 cyc <= cyc + 6'h01;
	mac_link_model m (.clk_sys, .reset_n, .fire, .rssi_go, .tmo_go, .mac_event, .rssi_sample, .hop_timeout);
	mac_link_statistics_and_routing_config #(.POLL_PERIOD_CYCLES(8)) dut (.clk_sys, .reset_n, .clk_en(clk_en),
		.host_cmd, .host_rsp, .mac_event, .rssi_sample, .hop_timeout, .network_hop_count(nh),
		.broadcast_received(cyc[0]), .poll_request_from_end(cyc[1]), .repeat_broadcast(rep),
		.route_enable(route), .hold_p2mp_unicast(hold), .release_p2mp_unicast(rel), .poll_send(poll),
		.broadcast_hop_effective(hop));
	task automatic eq(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// One command per call; the answer is looked at in the single cycle it stands
	task automatic op(input logic w, input logic [3:0] s, input logic [15:0] d, input logic [15:0] e, input logic ee);
		@(posedge clk_sys);
		#1 host_cmd = '{1'h1, w, s, d};
		fire = '0;
		@(posedge clk_sys);
		#1 host_cmd.valid = 1'h0;
		eq({host_rsp.valid, host_rsp.error}, {1'h1, ee});
		if (!w) eq(host_rsp.rdata, e);
	endtask
	task automatic pulse(input logic [5:0] f, input int k);
		@(posedge clk_sys);
		#1 fire = f;
		repeat (k) @(posedge clk_sys);
		#1 fire = '0;
	endtask
	task automatic results;
		if (bad_count == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys);
		#1 reset_n = 1'h1;
		for (n = 0; n < 11; n++) op(1'h0, 4'(n), 16'h0, n == 7 ? UNI_TMO_RESET : n == 8 ? BC_TMO_RESET : 16'h0, 1'h0);
		op(1'h1, SEL_TX_BYTE, 16'hFFFE, 16'h0, 1'h0);
		pulse(6'h01, 3);
		op(1'h0, SEL_TX_BYTE, 16'h0, 16'h0001, 1'h0);
		for (n = 1; n < 6; n++) begin
			op(1'h1, 4'(n), 16'hFFFE, 16'h0, 1'h0);
			pulse(6'(1 << n), 3);
			op(1'h0, 4'(n), 16'h0, 16'hFFFF, 1'h0);
		end
		fire = 6'h02;
		op(1'h1, SEL_RX_ERROR, 16'h1234, 16'h0, 1'h0);
		op(1'h0, SEL_RX_ERROR, 16'h0, 16'h1234, 1'h0);
		// Events arriving while the enable is low must be lost, not deferred
		clk_en = 1'h0;
		pulse(6'h02, 2);
		@(posedge clk_sys);
		#1 clk_en = 1'h1;
		op(1'h0, SEL_RX_ERROR, 16'h0, 16'h1234, 1'h0);
		@(posedge clk_sys);
		#1 {rssi_go, tmo_go} = 2'h3;
		@(posedge clk_sys);
		#1 {rssi_go, tmo_go} = 2'h0;
		op(1'h0, SEL_SIGNAL, 16'h0, 16'h0060, 1'h0);
		op(1'h0, SEL_UNI_TMO, 16'h0, 16'h0123, 1'h0);
		op(1'h0, SEL_BC_TMO, 16'h0, 16'h0456, 1'h0);
		for (n = 6; n < 9; n++) op(1'h1, 4'(n), 16'h0011, 16'h0, 1'h1);
		op(1'h0, SEL_SIGNAL, 16'h0, 16'h0060, 1'h0);
		op(1'h0, 4'hB, 16'h0, 16'h0, 1'h1);
		op(1'h1, 4'hB, 16'h0011, 16'h0, 1'h1);
		last = 3'h0;
		for (n = 0; n < 8; n++) begin
			op(1'h1, SEL_OPTIONS, 16'(n), 16'h0, n == 5 || n == 7);
			if (n != 5 && n != 7) last = 3'(n);
			eq({route, hold, rep, rel}, {!last[1], last[0], cyc[0] & !last[1], cyc[1] & last[0]});
			op(1'h0, SEL_OPTIONS, 16'h0, 16'(last), 1'h0);
		end
		op(1'h1, SEL_OPTIONS, 16'h0, 16'h0, 1'h0);
		op(1'h1, SEL_OPTIONS, 16'h0004, 16'h0, 1'h0);
		cnt = 0;
		repeat (20) begin
			@(posedge clk_sys);
			#1 cnt += int'(poll);
		end
		eq(16'(cnt), 16'h0002);
		for (n = 0; n < 4; n++) begin
			op(1'h1, SEL_HOP_LIMIT, n == 0 ? 16'h21 : n == 1 ? 16'h0 : n == 2 ? 16'h08 : 16'h20, 16'h0, n == 0);
			@(posedge clk_sys);
			#1 eq({10'h0, hop}, n == 2 ? 16'h08 : 16'h10);
		end
		nh = 6'h30;
		repeat (2) @(posedge clk_sys);
		#1 eq({10'h0, hop}, 16'h20);
		results;
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		bad_count++;
		results;
	end
endmodule
